/* File: hw/mcbd_branch_decode.sv */
// Conditional branch decode and program counter with AXI4-Lite registers
//
// What this block does
// - Taken relative jump loads counter with current instruction address plus offset.
// - Offset is five bits, two's complement, range minus sixteen to fifteen.
// - Control-bit branch jumps when issuing core's selected control bit matches polarity.
// - Four-bit select code n picks control word bit n.
// - Polarity zero wants the signal low, polarity one wants it high.
// - Opcode 001000: bit 9 polarity, bits 8-5 select, bits 4-0 offset.
// - Taken absolute feedback branch loads counter from the named jump register.
// - Jump register operand picks one of the jump registers, any target.
// - Feedback select: high-side pairs on 0-9, low-side drain on 10-15.
// - Opcode 001110 with tail 0100: select, polarity, jump register fields.
// - Opcode 000101: bits 9-6 select, bit 5 polarity, bits 4-0 offset.
// - Relative feedback branch jumps only on a feedback match.
// - Absolute feedback branch jumps only on a feedback match.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "mcbd_regs.svh"
module mcbd_branch_decode (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [`MCBD_AXI_AW-1:0]    s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [`MCBD_AXI_AW-1:0]    s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       instr_valid,
    input  wire logic [15:0]                instr_word,
    input  wire logic [1:0]                 core_index,
    input  wire logic [15:0]                driver_feedback,
    output logic [`MCBD_PC_W-1:0]           program_counter,
    output logic                            branch_decoded,
    output logic                            branch_taken
);
    import mcbd_pkg::*;

    // ------------------------------------------------------------------------
    // Register map helpers
    // ------------------------------------------------------------------------
    localparam logic [3:0][`MCBD_IDX_W-1:0] CTRL_IDX = {`MCBD_IDX_CTRL1B, `MCBD_IDX_CTRL0B,
                                                        `MCBD_IDX_CTRL1, `MCBD_IDX_CTRL0};

    mcbd_state_t            s;
    mcbd_state_t            next_s;
    mcbd_kind_t             eval_kind;
    logic                   eval_cond;
    logic [`MCBD_PC_W-1:0]  eval_pc;
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic [`MCBD_IDX_W-1:0] ar_idx;

    // ------------------------------------------------------------------------
    // Condition evaluation
    // ------------------------------------------------------------------------
    // Feedback only ever seen through the second sync stage
    mcbd_cond_eval u_eval (
        .instr_word   (instr_word),
        .pc           (s.pc),
        .ctrl_word    (s.ctrl[core_index]),
        .feedback     (s.fb_sync),
        .jump_target0 (s.jump[0]),
        .jump_target1 (s.jump[1]),
        .kind         (eval_kind),
        .cond_true    (eval_cond),
        .next_pc      (eval_pc)
    );

    // ------------------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------------------
    // Holding off address and data while a response waits keeps one write in flight
    assign s_axi_awready = !s.aw_hold && !s.bvalid;
    assign s_axi_wready  = !s.w_hold && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign ar_idx        = s_axi_araddr[`MCBD_AXI_AW-1:2];

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.fb_meta = driver_feedback;
        next_s.fb_sync = s.fb_meta;

        // Instruction step
        next_s.taken   = 1'b0;
        next_s.decoded = 1'b0;
        if (instr_valid) begin
            next_s.pc = eval_pc;
            if (eval_kind != MCBD_KIND_NONE) begin
                next_s.decoded    = 1'b1;
                next_s.taken      = eval_cond;
                next_s.last_kind  = eval_kind;
                next_s.last_taken = eval_cond;
            end
        end

        // Write channel
        if (aw_take) begin
            next_s.aw_hold = 1'b1;
            next_s.aw_idx  = s_axi_awaddr[`MCBD_AXI_AW-1:2];
        end
        if (w_take) begin
            next_s.w_hold = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.aw_hold && s.w_hold) begin
            next_s.aw_hold = 1'b0;
            next_s.w_hold  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = `MCBD_RESP_SLVERR;
            for (int i = 0; i < 4; i++) begin
                if (s.aw_idx == CTRL_IDX[i]) begin
                    next_s.bresp = `MCBD_RESP_OKAY;
                    if (s.w_strb[0]) begin
                        next_s.ctrl[i][7:0] = s.w_data[7:0];
                    end
                    if (s.w_strb[1]) begin
                        next_s.ctrl[i][15:8] = s.w_data[15:8];
                    end
                end
            end
            for (int j = 0; j < 2; j++) begin
                if (s.aw_idx == `MCBD_IDX_JUMP0 + `MCBD_IDX_W'(j)) begin
                    next_s.bresp = `MCBD_RESP_OKAY;
                    if (s.w_strb[0]) begin
                        next_s.jump[j][7:0] = s.w_data[7:0];
                    end
                    if (s.w_strb[1]) begin
                        next_s.jump[j][`MCBD_PC_W-1:8] = s.w_data[`MCBD_PC_W-1:8];
                    end
                end
            end
            // Status is read-only, a write is accepted and dropped
            if (s.aw_idx == `MCBD_IDX_STATUS) begin
                next_s.bresp = `MCBD_RESP_OKAY;
            end
        end else if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Read channel
        if (ar_take) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `MCBD_RESP_SLVERR;
            next_s.rdata  = 32'h0000_0000;
            for (int k = 0; k < 4; k++) begin
                if (ar_idx == CTRL_IDX[k]) begin
                    next_s.rresp = `MCBD_RESP_OKAY;
                    next_s.rdata = {16'h0000, s.ctrl[k]};
                end
            end
            for (int m = 0; m < 2; m++) begin
                if (ar_idx == `MCBD_IDX_JUMP0 + `MCBD_IDX_W'(m)) begin
                    next_s.rresp = `MCBD_RESP_OKAY;
                    next_s.rdata = {{(32-`MCBD_PC_W){1'b0}}, s.jump[m]};
                end
            end
            if (ar_idx == `MCBD_IDX_STATUS) begin
                next_s.rresp = `MCBD_RESP_OKAY;
                next_s.rdata[`MCBD_PC_W-1:0] = s.pc;
                next_s.rdata[`MCBD_ST_KIND_HI:`MCBD_ST_KIND_LO] = s.last_kind;
                next_s.rdata[`MCBD_ST_TAKEN] = s.last_taken;
            end
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s            <= '0;
            s.ctrl       <= {4{`MCBD_RST_CTRL}};
            s.jump       <= {2{`MCBD_RST_JUMP}};
            s.pc         <= `MCBD_RST_PC;
            s.last_kind  <= MCBD_KIND_NONE;
        end else begin
            s <= next_s;
        end
    end

    assign program_counter = s.pc;
    assign branch_decoded  = s.decoded;
    assign branch_taken    = s.taken;
    assign s_axi_bvalid    = s.bvalid;
    assign s_axi_bresp     = s.bresp;
    assign s_axi_rvalid    = s.rvalid;
    assign s_axi_rdata     = s.rdata;
    assign s_axi_rresp     = s.rresp;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    // Independent reference so a slip in the evaluator shows up
    logic [5:0]             chk_opc;
    logic [`MCBD_PC_W-1:0]  chk_rel;
    logic                   chk_ctrl_bit;
    logic                   chk_fbk_bit;
    logic                   chk_is_abs;
    logic                   chk_is_branch;

    assign chk_opc       = instr_word[15:10];
    assign chk_rel       = s.pc + `MCBD_PC_W'($signed(instr_word[4:0]));
    assign chk_ctrl_bit  = s.ctrl[core_index][instr_word[8:5]];
    assign chk_fbk_bit   = s.fb_sync[instr_word[9:6]];
    assign chk_is_abs    = chk_opc == 6'h0E && instr_word[3:0] == 4'h4;
    assign chk_is_branch = chk_opc == 6'h08 || chk_opc == 6'h05 || chk_is_abs;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence rel_ctrl_hit;
        instr_valid && chk_opc == 6'h08 && chk_ctrl_bit == instr_word[9];
    endsequence

    sequence rel_ctrl_miss;
        instr_valid && chk_opc == 6'h08 && chk_ctrl_bit != instr_word[9];
    endsequence

    sequence fbk_steady;
        $stable(driver_feedback) [*3];
    endsequence

    sequence write_pair_held;
        s.aw_hold && s.w_hold;
    endsequence

    a_rel_ctrl_jump: assert property (rel_ctrl_hit |=> branch_taken &&
        program_counter == $past(chk_rel))
        else $error("control-bit branch did not jump to relative target");

    a_rel_ctrl_fall: assert property (rel_ctrl_miss |=> !branch_taken &&
        program_counter == $past(s.pc) + `MCBD_PC_W'(1))
        else $error("failed control-bit branch did not step by one");

    a_offset_range: assert property (instr_valid && chk_opc == 6'h05 && eval_cond |=>
        $signed(program_counter - $past(s.pc)) >= -16 && $signed(program_counter - $past(s.pc)) <= 15)
        else $error("relative jump outside offset range");

    a_abs_fbk_jump: assert property (instr_valid && chk_is_abs && chk_fbk_bit == instr_word[5] |=>
        program_counter == $past(s.jump[instr_word[4]]))
        else $error("absolute feedback branch missed jump register target");

    a_rel_fbk_gate: assert property (instr_valid && chk_opc == 6'h05 |=>
        branch_taken == ($past(chk_fbk_bit) == $past(instr_word[5])))
        else $error("relative feedback branch taken on wrong polarity");

    a_fbk_pin_path: assert property (fbk_steady ##0 instr_valid && chk_opc == 6'h05 &&
        driver_feedback[instr_word[9:6]] == instr_word[5] |=> branch_taken)
        else $error("steady feedback pin not seen by branch");

    a_decode_match: assert property (instr_valid |=> branch_decoded == $past(chk_is_branch))
        else $error("branch opcode decode mismatch");

    a_nonbranch_step: assert property (instr_valid && !chk_is_branch |=> !branch_taken &&
        program_counter == $past(s.pc) + `MCBD_PC_W'(1))
        else $error("non-branch instruction moved counter wrongly");

    a_write_answer: assert property (write_pair_held |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing after address and data");

    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before acceptance");

    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before acceptance");

    a_idle_pc: assert property (!instr_valid |=> $stable(program_counter) && !branch_decoded)
        else $error("counter moved with no instruction");

endmodule // mcbd_branch_decode

/* File: shared/mcbd_regs.svh */
// Offsets, field positions, reset values and widths of the branch decode block
`ifndef MCBD_REGS_SVH
`define MCBD_REGS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define MCBD_PC_W          10
`define MCBD_AXI_AW        12
`define MCBD_IDX_W         10

// ----------------------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define MCBD_IDX_CTRL0     10'h101
`define MCBD_IDX_CTRL1     10'h102
`define MCBD_IDX_CTRL0B    10'h121
`define MCBD_IDX_CTRL1B    10'h122
`define MCBD_IDX_JUMP0     10'h130
`define MCBD_IDX_JUMP1     10'h131
`define MCBD_IDX_STATUS    10'h140

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MCBD_RST_CTRL      16'h0000
`define MCBD_RST_JUMP      10'h000
`define MCBD_RST_PC        10'h000

// ----------------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------------
`define MCBD_OPC_HI        15
`define MCBD_OPC_LO        10
`define MCBD_OPC_REL_CTRL  6'h08
`define MCBD_OPC_ABS_FBK   6'h0E
`define MCBD_OPC_REL_FBK   6'h05
`define MCBD_TAIL_HI       3
`define MCBD_ABS_TAIL      4'h4
`define MCBD_CPOL_BIT      9
`define MCBD_CSEL_HI       8
`define MCBD_CSEL_LO       5
`define MCBD_FSEL_HI       9
`define MCBD_FSEL_LO       6
`define MCBD_FPOL_BIT      5
`define MCBD_JSEL_BIT      4
`define MCBD_OFF_HI        4
`define MCBD_OFF_W         5

// ----------------------------------------------------------------------------
// Status word and bus answers
// ----------------------------------------------------------------------------
`define MCBD_ST_KIND_LO    10
`define MCBD_ST_KIND_HI    13
`define MCBD_ST_TAKEN      14
`define MCBD_RESP_OKAY     2'h0
`define MCBD_RESP_SLVERR   2'h2

`endif

/* File: shared/mcbd_pkg.sv */
// Types shared by the branch decode block
`include "mcbd_regs.svh"
package mcbd_pkg;

    // ------------------------------------------------------------------------
    // Decoded instruction kind, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        MCBD_KIND_NONE     = 4'h1,
        MCBD_KIND_REL_CTRL = 4'h2,
        MCBD_KIND_ABS_FBK  = 4'h4,
        MCBD_KIND_REL_FBK  = 4'h8
    } mcbd_kind_t;

    // ------------------------------------------------------------------------
    // Whole state of the top module
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]                        fb_meta;
        logic [15:0]                        fb_sync;
        logic [3:0][15:0]                   ctrl;
        logic [1:0][`MCBD_PC_W-1:0]         jump;
        logic [`MCBD_PC_W-1:0]              pc;
        logic                               taken;
        logic                               decoded;
        mcbd_kind_t                         last_kind;
        logic                               last_taken;
        logic                               aw_hold;
        logic [`MCBD_IDX_W-1:0]             aw_idx;
        logic                               w_hold;
        logic [31:0]                        w_data;
        logic [3:0]                         w_strb;
        logic                               bvalid;
        logic [1:0]                         bresp;
        logic                               rvalid;
        logic [31:0]                        rdata;
        logic [1:0]                         rresp;
    } mcbd_state_t;

endpackage

/* File: hw/mcbd_cond_eval.sv */
// Condition test and next program counter for the conditional branches
`timescale 1ns/1ps
`include "mcbd_regs.svh"
module mcbd_cond_eval (
    input  wire logic [15:0]            instr_word,
    input  wire logic [`MCBD_PC_W-1:0]  pc,
    input  wire logic [15:0]            ctrl_word,
    input  wire logic [15:0]            feedback,
    input  wire logic [`MCBD_PC_W-1:0]  jump_target0,
    input  wire logic [`MCBD_PC_W-1:0]  jump_target1,
    output mcbd_pkg::mcbd_kind_t        kind,
    output logic                        cond_true,
    output logic [`MCBD_PC_W-1:0]       next_pc
);
    import mcbd_pkg::*;

    logic [5:0]             opc;
    logic [`MCBD_PC_W-1:0]  rel_pc;
    logic [`MCBD_PC_W-1:0]  seq_pc;

    assign opc = instr_word[`MCBD_OPC_HI:`MCBD_OPC_LO];
    assign rel_pc = pc + {{(`MCBD_PC_W-`MCBD_OFF_W){instr_word[`MCBD_OFF_HI]}}, instr_word[`MCBD_OFF_HI:0]};
    assign seq_pc = pc + `MCBD_PC_W'(1);

    always_comb begin
        kind      = MCBD_KIND_NONE;
        cond_true = 1'b0;
        next_pc   = seq_pc;
        case (opc)
            `MCBD_OPC_REL_CTRL: begin
                kind = MCBD_KIND_REL_CTRL;
                cond_true = ctrl_word[instr_word[`MCBD_CSEL_HI:`MCBD_CSEL_LO]] == instr_word[`MCBD_CPOL_BIT];
                if (cond_true) begin
                    next_pc = rel_pc;
                end
            end
            `MCBD_OPC_REL_FBK: begin
                kind = MCBD_KIND_REL_FBK;
                cond_true = feedback[instr_word[`MCBD_FSEL_HI:`MCBD_FSEL_LO]] == instr_word[`MCBD_FPOL_BIT];
                if (cond_true) begin
                    next_pc = rel_pc;
                end
            end
            `MCBD_OPC_ABS_FBK: begin
                if (instr_word[`MCBD_TAIL_HI:0] == `MCBD_ABS_TAIL) begin
                    kind = MCBD_KIND_ABS_FBK;
                    cond_true = feedback[instr_word[`MCBD_FSEL_HI:`MCBD_FSEL_LO]] == instr_word[`MCBD_FPOL_BIT];
                    if (cond_true) begin
                        next_pc = instr_word[`MCBD_JSEL_BIT] ? jump_target1 : jump_target0;
                    end
                end
            end
            default: begin
                kind = MCBD_KIND_NONE;
            end
        endcase
    end

endmodule // mcbd_cond_eval

/* File: sim/mcbd_seq_model.sv */
// Code RAM and fetch model of the issuing sequencer
`timescale 1ns/1ps
`include "mcbd_regs.svh"
module mcbd_seq_model (
    input  wire logic                   aclk,
    input  wire logic                   go,
    input  wire logic                   load_en,
    input  wire logic [`MCBD_PC_W-1:0]  load_addr,
    input  wire logic [15:0]            load_data,
    input  wire logic [`MCBD_PC_W-1:0]  program_counter,
    output logic                        instr_valid,
    output logic [15:0]                 instr_word
);
    // ------------------------------------------------------------------------
    // Code RAM and fetch
    // ------------------------------------------------------------------------
    logic [15:0] ram [1024];

    always_ff @(posedge aclk) begin
        if (load_en) begin
            ram[load_addr] <= load_data;
        end
    end

    // Fetch follows the counter, so a wrong counter fetches a wrong word
    assign instr_valid = go;
    // Idle word bus shows inverted data, a stale word cannot pass for a fetch
    assign instr_word  = go ? ram[program_counter] : ~ram[program_counter];
endmodule // mcbd_seq_model

/* File: sim/mcbd_branch_decode_tb.sv */
// Self-checking bench of the conditional branch decode block
`timescale 1ns/1ps
`include "mcbd_regs.svh"
module mcbd_branch_decode_tb;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic                aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, load_en, seen;
    logic                awready, wready, bvalid, arready, rvalid, instr_valid, dec, tkn;
    logic [11:0]         awaddr, araddr, note, last_br;
    logic [31:0]         wdata, rdata, r;
    logic [3:0]          wstrb;
    logic [1:0]          bresp, rresp, core;
    logic [15:0]         fb_m, instr_word, load_data;
    logic [9:0]          pc, pc_m, load_addr;
    logic [15:0]         ctrl_m [4];
    logic [9:0]          jmp_m [2];
    logic [11:0]         notes [$];
    int                  failures, n_compared, cycles, seed;
    localparam logic [9:0] CIDX [4] = '{`MCBD_IDX_CTRL0, `MCBD_IDX_CTRL1, `MCBD_IDX_CTRL0B, `MCBD_IDX_CTRL1B};
    localparam logic [9:0] JIDX [2] = '{`MCBD_IDX_JUMP0, `MCBD_IDX_JUMP1};

    mcbd_branch_decode uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .instr_valid(instr_valid),
        .instr_word(instr_word), .core_index(core), .driver_feedback(fb_m), .program_counter(pc),
        .branch_decoded(dec), .branch_taken(tkn));
    mcbd_seq_model seq (.aclk(aclk), .go(go), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .program_counter(pc), .instr_valid(instr_valid), .instr_word(instr_word));

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Ready sampled before the edge's updates land, so release follows the handshake
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // Reference: {decoded, taken, next counter}
    function automatic logic [11:0] ref_op(input logic [15:0] w, input logic [1:0] c);
        logic [9:0] tgt;
        logic       hit;
        logic       d;
        tgt = pc_m + {{5{w[4]}}, w[4:0]};
        d   = 1'b1;
        hit = 1'b0;
        case (w[15:10])
            6'h08: hit = ctrl_m[c][w[8:5]] == w[9];
            6'h05: hit = fb_m[w[9:6]] == w[5];
            6'h0E: begin
                d   = w[3:0] == 4'h4;
                hit = d && fb_m[w[9:6]] == w[5];
                tgt = jmp_m[w[4]];
            end
            default: d = 1'b0;
        endcase
        return {d, hit, hit ? tgt : pc_m + 10'h1};
    endfunction

    task automatic run_op(input logic [15:0] w, input logic [1:0] c);
        logic [11:0] e;
        e = ref_op(w, c);
        core      <= c;
        load_en   <= 1'b1;
        load_addr <= pc_m;
        load_data <= w;
        @(posedge aclk);
        load_en <= 1'b0;
        go      <= 1'b1;
        notes.push_back(e);
        if (e[11]) last_br = e;
        pc_m = e[9:0];
        @(posedge aclk);
        go <= 1'b0;
    endtask

    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Clock, timeout and result watcher
    // ------------------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            give_verdict();
        end
        if (seen) begin
            note = notes.pop_front();
            chk("next pc", {22'h0, note[9:0]}, {22'h0, pc});
            chk("decoded taken", {30'h0, note[11:10]}, {30'h0, dec, tkn});
        end
        seen <= instr_valid;
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        seed = 32'hd76b;
        {aresetn, awvalid, wvalid, arvalid, go, load_en, awaddr, araddr, wdata, core, fb_m} = '0;
        {load_addr, load_data, pc_m} = '0;
        {bready, rready, wstrb} = 6'h3F;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset pc", 32'h0, {22'h0, pc});
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            ctrl_m[i] = r[15:0];
            axr({CIDX[i], 2'b00}, 32'h0, `MCBD_RESP_OKAY);
            axw({CIDX[i], 2'b00}, r, `MCBD_RESP_OKAY);
            axr({CIDX[i], 2'b00}, {16'h0, r[15:0]}, `MCBD_RESP_OKAY);
        end
        for (int j = 0; j < 2; j++) begin
            r = $random(seed);
            jmp_m[j] = r[9:0];
            axw({JIDX[j], 2'b00}, r, `MCBD_RESP_OKAY);
            axr({JIDX[j], 2'b00}, {22'h0, r[9:0]}, `MCBD_RESP_OKAY);
        end
        axw(12'h7F0, r, `MCBD_RESP_SLVERR);
        axr(12'h7F0, 32'h0, `MCBD_RESP_SLVERR);
        axw({`MCBD_IDX_STATUS, 2'b00}, r, `MCBD_RESP_OKAY);
        axr({`MCBD_IDX_STATUS, 2'b00}, 32'h0000_0400, `MCBD_RESP_OKAY);
        $display("register test done");
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 32; k++) begin
                r = $random(seed);
                r[4:0] = k[4:1] == 4'h0 ? 5'h10 : (k[4:1] == 4'hF ? 5'h0F : r[4:0]);
                run_op({6'h08, k[0], k[4:1], r[4:0]}, c[1:0]);
            end
        end
        $display("control branch test done");
        for (int f = 0; f < 3; f++) begin
            r = $random(seed);
            fb_m <= r[15:0];
            repeat (3) @(posedge aclk);
            for (int k = 0; k < 32; k++) begin
                r = $random(seed);
                run_op({6'h05, k[4:1], k[0], r[4:0]}, r[6:5]);
                run_op({6'h0E, k[4:1], k[0], r[7], 4'h4}, r[6:5]);
            end
        end
        $display("feedback branch test done");
        run_op({6'h0E, 4'h3, 1'b1, 1'b0, 4'h5}, 2'h0);
        run_op(16'hFFFF, 2'h1);
        axr({`MCBD_IDX_STATUS, 2'b00}, {17'h0, last_br[10], 4'h4, pc_m}, `MCBD_RESP_OKAY);
        repeat (2) @(posedge aclk);
        $display("decode edge test done");
        give_verdict();
    end
endmodule // mcbd_branch_decode_tb
